// file: logic/pilc_pkg.sv
// Package of constants and types for the parallel issue legality checker
package pilc_pkg;

  // --------------------
  // Pair limits
  // --------------------
  localparam int unsigned PAIR_MAX_BYTES = 6;
  localparam int unsigned MAX_DATA_AGEN  = 2;
  localparam int unsigned MAX_COEF_AGEN  = 1;
  localparam int unsigned MAX_STACK_AGEN = 1;

  // --------------------
  // Operator mask bit positions
  // --------------------
  localparam int unsigned OP_D_ALU   = 0;
  localparam int unsigned OP_D_SHIFT = 1;
  localparam int unsigned OP_D_SWAP  = 2;
  localparam int unsigned OP_A_SWAP  = 3;
  localparam int unsigned OP_A_ALU   = 4;
  localparam int unsigned OP_P_UNIT  = 5;
  localparam int unsigned OP_W       = 6;

  // --------------------
  // Instruction class flag positions
  // --------------------
  localparam int unsigned CL_FAR_BRANCH = 0;
  localparam int unsigned CL_FAR_CALL   = 1;
  localparam int unsigned CL_IDLE       = 2;
  localparam int unsigned CL_SWINT      = 3;
  localparam int unsigned CL_SWRESET    = 4;
  localparam int unsigned CL_TRAP       = 5;
  localparam int unsigned CL_CALL       = 6;
  localparam int unsigned CL_PUSH       = 7;
  localparam int unsigned CL_POP        = 8;
  localparam int unsigned CL_RET        = 9;
  localparam int unsigned CL_RETI       = 10;
  localparam int unsigned CL_BRANCH     = 11;
  localparam int unsigned CL_REPEAT     = 12;
  localparam int unsigned CL_COND_EXEC  = 13;
  localparam int unsigned CL_ROUND      = 14;
  localparam int unsigned CL_STBIT      = 15;
  localparam int unsigned CL_LD_DPAGE   = 16;
  localparam int unsigned CL_LD_RETURN_ADDRESS_REG    = 17;
  localparam int unsigned CL_SWAP       = 18;
  localparam int unsigned CL_SP_MOD     = 19;
  localparam int unsigned CL_BYTE_ACC   = 20;
  localparam int unsigned CL_DELAY      = 21;
  localparam int unsigned CL_W          = 22;

  // --------------------
  // Operand qualifier flag positions
  // --------------------
  localparam int unsigned QF_MMR      = 0;
  localparam int unsigned QF_PORT     = 1;
  localparam int unsigned QF_CIRC_SFX = 2;
  localparam int unsigned QF_LIN_SFX  = 3;
  localparam int unsigned QF_W        = 4;

  // --------------------
  // Memory addressing modes
  // --------------------
  typedef enum logic [2:0] {
    AM_NONE   = 3'h0,
    AM_IND    = 3'h1,
    AM_ABS16  = 3'h2,
    AM_ABS23  = 3'h3,
    AM_PORT16 = 3'h4,
    AM_OFS16  = 3'h5,
    AM_DIRECT = 3'h6
  } pilc_amode_t;

  // --------------------
  // Coefficient pointer modifications
  // --------------------
  typedef enum logic [2:0] {
    CM_NONE = 3'h0,
    CM_IND  = 3'h1,
    CM_INC  = 3'h2,
    CM_DEC  = 3'h3,
    CM_IDX  = 3'h4
  } pilc_cmod_t;

  // Index source selected by the compatibility bit
  localparam logic IDX_SEL_TEMP = 1'b0;

  // --------------------
  // Checker state
  // --------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_ISSUE = 2'b10
  } pilc_state_t;

endpackage : pilc_pkg

// file: logic/pilc_checker.sv
// Parallel issue legality checker for one decoded instruction pair
//
// What this block does
// [RL1] Byte access to mapped register raises bus error.
// [RL2] Coefficient modes ind, inc, dec, index via temp or aux zero.
// [RL3] I/O with 16-bit offset or delay raises bus error.
// [RL4] Pair over six bytes refused.
// [RL5] Pair needs enable bit or soft-dual.
// [RL6] No 16-bit constant modes in pairs.
// [RL7] Far branch, far call, idle, interrupt, reset, trap never pair.
// [RL8] No mmr, port or override qualifiers in pairs.
// [RL9] One write per register per phase.
// [RL10] Stack pointer change never pairs with stack users.
// [RL11] Shared status bit write flagged undefined.
// [RL12] Shared operator refused.
// [RL13] At most 2 data, 1 coef, 1 stack generator.
// [RL14] Resource union over hardware limits is a conflict.
// [RL15] Flag non-repeatable classes under repeat.
// [RL16] Both coefficient operands use one pointer change.
// [RL17] Unsigned qualifiers match on paired operands.
// [RL18] Legal pair issues both in one cycle.
// [RL19] Illegal pair output pulses one cycle.
`timescale 1ns/1ps
`default_nettype none

module pilc_checker #(
  parameter int unsigned REG_W = 6,
  parameter int unsigned LEN_W = 3
) (
  input  wire logic                         CLK_IN,
  input  wire logic                         SRST_IN,
  input  wire logic                         CE_IN,
  input  wire logic                         VALID_IN,
  input  wire logic                         PAIR_IN,
  input  wire logic                         REPEAT_IN,
  input  wire logic                         LEGACY_COMPAT_BIT_IN,
  input  wire logic [LEN_W-1:0]             LEN_A_IN,
  input  wire logic [LEN_W-1:0]             LEN_B_IN,
  input  wire logic                         PAR_EN_A_IN,
  input  wire logic                         PAR_EN_B_IN,
  input  wire logic                         SOFT_DUAL_IN,
  input  wire logic [pilc_pkg::CL_W-1:0]    CLASS_A_IN,
  input  wire logic [pilc_pkg::CL_W-1:0]    CLASS_B_IN,
  input  wire logic [pilc_pkg::OP_W-1:0]    OPS_A_IN,
  input  wire logic [pilc_pkg::OP_W-1:0]    OPS_B_IN,
  input  wire logic [pilc_pkg::QF_W-1:0]    QUAL_A_IN,
  input  wire logic [pilc_pkg::QF_W-1:0]    QUAL_B_IN,
  input  wire pilc_pkg::pilc_amode_t        AMODE_A_IN,
  input  wire pilc_pkg::pilc_amode_t        AMODE_B_IN,
  input  wire logic                         IO_ACC_A_IN,
  input  wire logic                         IO_ACC_B_IN,
  input  wire logic                         MMR_TGT_A_IN,
  input  wire logic                         MMR_TGT_B_IN,
  input  wire logic [1:0]                   DAGEN_A_IN,
  input  wire logic [1:0]                   DAGEN_B_IN,
  input  wire logic                         CAGEN_A_IN,
  input  wire logic                         CAGEN_B_IN,
  input  wire logic                         SAGEN_A_IN,
  input  wire logic                         SAGEN_B_IN,
  input  wire logic                         WR_EN_A_IN,
  input  wire logic                         WR_EN_B_IN,
  input  wire logic [REG_W-1:0]             WR_REG_A_IN,
  input  wire logic [REG_W-1:0]             WR_REG_B_IN,
  input  wire logic [(1<<REG_W)-1:0]        SWAP_SET_A_IN,
  input  wire logic [(1<<REG_W)-1:0]        SWAP_SET_B_IN,
  input  wire logic                         PTR_MOD_A_IN,
  input  wire logic                         PTR_MOD_B_IN,
  input  wire logic [2:0]                   PTR_ID_A_IN,
  input  wire logic [2:0]                   PTR_ID_B_IN,
  input  wire logic [1:0]                   PTR_STEP_A_IN,
  input  wire logic [1:0]                   PTR_STEP_B_IN,
  input  wire pilc_pkg::pilc_cmod_t         CMOD_A_IN,
  input  wire pilc_pkg::pilc_cmod_t         CMOD_B_IN,
  input  wire logic                         CUNS_A_IN,
  input  wire logic                         CUNS_B_IN,
  input  wire logic                         XY_DUAL_IN,
  input  wire logic                         XUNS_IN,
  input  wire logic                         YUNS_IN,
  input  wire logic [15:0]                  STBIT_A_IN,
  input  wire logic [15:0]                  STBIT_B_IN,
  output logic                              ISSUE_OUT,
  output logic                              ISSUE_PAIR_OUT,
  output logic                              ILLEGAL_PAIR_OUT,
  output logic                              NOT_REPEATABLE_OUT,
  output logic                              BUS_ERROR_IRQ_OUT,
  output logic                              STBIT_UNDEF_OUT,
  output logic                              COEF_IDX_AUX_OUT,
  output logic                              COEF_MODE_ERR_OUT
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic needs_k16(input pilc_pkg::pilc_amode_t m);
    needs_k16 = (m == pilc_pkg::AM_ABS16) || (m == pilc_pkg::AM_ABS23) ||
                (m == pilc_pkg::AM_PORT16) || (m == pilc_pkg::AM_OFS16);
  endfunction : needs_k16

  function automatic logic no_pair_class(input logic [pilc_pkg::CL_W-1:0] c);
    no_pair_class = c[pilc_pkg::CL_FAR_BRANCH] | c[pilc_pkg::CL_FAR_CALL] | c[pilc_pkg::CL_IDLE] |
                    c[pilc_pkg::CL_SWINT] | c[pilc_pkg::CL_SWRESET] | c[pilc_pkg::CL_TRAP];
  endfunction : no_pair_class

  function automatic logic stack_user(input logic [pilc_pkg::CL_W-1:0] c);
    stack_user = c[pilc_pkg::CL_CALL] | c[pilc_pkg::CL_FAR_CALL] | c[pilc_pkg::CL_PUSH] |
                 c[pilc_pkg::CL_POP] | c[pilc_pkg::CL_RET] | c[pilc_pkg::CL_RETI] |
                 c[pilc_pkg::CL_TRAP] | c[pilc_pkg::CL_SWINT];
  endfunction : stack_user

  function automatic logic non_repeat(input logic [pilc_pkg::CL_W-1:0] c);
    non_repeat = c[pilc_pkg::CL_BRANCH] | c[pilc_pkg::CL_FAR_BRANCH] | c[pilc_pkg::CL_CALL] |
                 c[pilc_pkg::CL_FAR_CALL] | c[pilc_pkg::CL_RET] | c[pilc_pkg::CL_RETI] |
                 c[pilc_pkg::CL_IDLE] | c[pilc_pkg::CL_SWINT] | c[pilc_pkg::CL_SWRESET] |
                 c[pilc_pkg::CL_TRAP] | c[pilc_pkg::CL_REPEAT] | c[pilc_pkg::CL_COND_EXEC] |
                 c[pilc_pkg::CL_ROUND] | c[pilc_pkg::CL_STBIT] | c[pilc_pkg::CL_LD_DPAGE] |
                 c[pilc_pkg::CL_LD_RETURN_ADDRESS_REG];
  endfunction : non_repeat

  function automatic logic illegal_io(input logic io, input pilc_pkg::pilc_amode_t m,
                                      input logic [pilc_pkg::CL_W-1:0] c);
    illegal_io = io & ((m == pilc_pkg::AM_OFS16) | c[pilc_pkg::CL_DELAY]);
  endfunction : illegal_io

  function automatic logic bad_cmode(input pilc_pkg::pilc_cmod_t m);
    bad_cmode = !((m == pilc_pkg::CM_NONE) || (m == pilc_pkg::CM_IND) || (m == pilc_pkg::CM_INC) ||
                  (m == pilc_pkg::CM_DEC) || (m == pilc_pkg::CM_IDX));
  endfunction : bad_cmode

  // ----------------------------------------------------------------
  // Pair checks
  // ----------------------------------------------------------------
  logic [LEN_W:0] total_len;
  logic [2:0]     dagen_sum;
  logic [1:0]     cagen_sum;
  logic [1:0]     sagen_sum;
  logic           err_size;
  logic           err_enable;
  logic           err_k16;
  logic           err_class;
  logic           err_qual;
  logic           err_write;
  logic           err_stack;
  logic           err_oper;
  logic           err_agen;
  logic           err_coef;
  logic           err_uns;
  logic           pair_bad;
  logic           berr_a;
  logic           berr_b;
  logic           rpt_bad;

  assign total_len  = {1'b0, LEN_A_IN} + {1'b0, LEN_B_IN};
  assign err_size   = total_len > (LEN_W+1)'(pilc_pkg::PAIR_MAX_BYTES);            // [RL4]
  assign err_enable = !(PAR_EN_A_IN | PAR_EN_B_IN | SOFT_DUAL_IN);                  // [RL5]
  assign err_k16    = needs_k16(AMODE_A_IN) | needs_k16(AMODE_B_IN);                // [RL6]
  assign err_class  = no_pair_class(CLASS_A_IN) | no_pair_class(CLASS_B_IN);        // [RL7]
  assign err_qual   = |QUAL_A_IN | |QUAL_B_IN;                                      // [RL8]

  // Write-once per phase: same register, pointer clash, swap overlap
  assign err_write =
      (WR_EN_A_IN & WR_EN_B_IN & (WR_REG_A_IN == WR_REG_B_IN)) |                   // [RL9]
      (PTR_MOD_A_IN & PTR_MOD_B_IN & (PTR_ID_A_IN == PTR_ID_B_IN) &
       (PTR_STEP_A_IN != PTR_STEP_B_IN)) |                                          // [RL9]
      (CLASS_A_IN[pilc_pkg::CL_SWAP] & WR_EN_B_IN & SWAP_SET_A_IN[WR_REG_B_IN]) |  // [RL9]
      (CLASS_B_IN[pilc_pkg::CL_SWAP] & WR_EN_A_IN & SWAP_SET_B_IN[WR_REG_A_IN]) |  // [RL9]
      (CLASS_A_IN[pilc_pkg::CL_SWAP] & CLASS_B_IN[pilc_pkg::CL_SWAP] &
       |(SWAP_SET_A_IN & SWAP_SET_B_IN));                                           // [RL9]

  assign err_stack = (CLASS_A_IN[pilc_pkg::CL_SP_MOD] & stack_user(CLASS_B_IN)) |
                     (CLASS_B_IN[pilc_pkg::CL_SP_MOD] & stack_user(CLASS_A_IN));    // [RL10]

  assign err_oper  = |(OPS_A_IN & OPS_B_IN);                                        // [RL12]

  // Union of address generators against the hardware count
  assign dagen_sum = {1'b0, DAGEN_A_IN} + {1'b0, DAGEN_B_IN};                       // [RL14]
  assign cagen_sum = {1'b0, CAGEN_A_IN} + {1'b0, CAGEN_B_IN};
  assign sagen_sum = {1'b0, SAGEN_A_IN} + {1'b0, SAGEN_B_IN};
  assign err_agen  = (dagen_sum > 3'(pilc_pkg::MAX_DATA_AGEN)) |
                     (cagen_sum > 2'(pilc_pkg::MAX_COEF_AGEN)) |
                     (sagen_sum > 2'(pilc_pkg::MAX_STACK_AGEN));                    // [RL13]

  assign err_coef = (CMOD_A_IN != pilc_pkg::CM_NONE) & (CMOD_B_IN != pilc_pkg::CM_NONE) &
                    (CMOD_A_IN != CMOD_B_IN);                                       // [RL16]
  assign err_uns  = ((CMOD_A_IN != pilc_pkg::CM_NONE) & (CMOD_B_IN != pilc_pkg::CM_NONE) &
                     (CUNS_A_IN != CUNS_B_IN)) |
                    (XY_DUAL_IN & (XUNS_IN != YUNS_IN));                            // [RL17]

  assign pair_bad = err_size | err_enable | err_k16 | err_class | err_qual | err_write |
                    err_stack | err_oper | err_agen | err_coef | err_uns;          // [RL14]

  // Illegal memory accesses answered by a bus error
  assign berr_a = (CLASS_A_IN[pilc_pkg::CL_BYTE_ACC] & MMR_TGT_A_IN) |             // [RL1]
                  illegal_io(IO_ACC_A_IN, AMODE_A_IN, CLASS_A_IN);                  // [RL3]
  assign berr_b = PAIR_IN & ((CLASS_B_IN[pilc_pkg::CL_BYTE_ACC] & MMR_TGT_B_IN) |  // [RL1]
                  illegal_io(IO_ACC_B_IN, AMODE_B_IN, CLASS_B_IN));                 // [RL3]

  assign rpt_bad = REPEAT_IN & (non_repeat(CLASS_A_IN) |
                                (PAIR_IN & non_repeat(CLASS_B_IN)));                // [RL15]

  // ----------------------------------------------------------------
  // Issue state
  // ----------------------------------------------------------------
  pilc_pkg::pilc_state_t state_reg;
  pilc_pkg::pilc_state_t state_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pilc_pkg::ST_IDLE: begin
        if (VALID_IN) begin
          state_next = pilc_pkg::ST_ISSUE;
        end
      end
      pilc_pkg::ST_ISSUE: begin
        if (!VALID_IN) begin
          state_next = pilc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = pilc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      state_reg <= pilc_pkg::ST_IDLE;
    end else if (CE_IN) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Issue and error outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ISSUE_OUT        <= 1'b0;
      ISSUE_PAIR_OUT   <= 1'b0;
      ILLEGAL_PAIR_OUT <= 1'b0;
    end else if (CE_IN) begin
      ILLEGAL_PAIR_OUT <= VALID_IN & PAIR_IN & pair_bad;                            // [RL19]
      ISSUE_OUT        <= VALID_IN & !(PAIR_IN & pair_bad) & !berr_a & !berr_b;     // [RL18]
      ISSUE_PAIR_OUT   <= VALID_IN & PAIR_IN & !pair_bad & !berr_a & !berr_b;       // [RL18]
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      BUS_ERROR_IRQ_OUT <= 1'b0;
    end else if (CE_IN) begin
      BUS_ERROR_IRQ_OUT <= VALID_IN & (berr_a | berr_b);                            // [RL1] [RL3]
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      NOT_REPEATABLE_OUT <= 1'b0;
    end else if (CE_IN) begin
      NOT_REPEATABLE_OUT <= VALID_IN & rpt_bad;                                     // [RL15]
    end
  end

  // Status bit written by both halves: result flagged undefined
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      STBIT_UNDEF_OUT <= 1'b0;
    end else if (CE_IN) begin
      STBIT_UNDEF_OUT <= VALID_IN & PAIR_IN & !pair_bad & |(STBIT_A_IN & STBIT_B_IN); // [RL11]
    end
  end

  // Coefficient index source and mode check
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      COEF_IDX_AUX_OUT  <= 1'b0;
      COEF_MODE_ERR_OUT <= 1'b0;
    end else if (CE_IN) begin
      COEF_IDX_AUX_OUT  <= VALID_IN & (CMOD_A_IN == pilc_pkg::CM_IDX) &
                           (LEGACY_COMPAT_BIT_IN != pilc_pkg::IDX_SEL_TEMP);        // [RL2]
      COEF_MODE_ERR_OUT <= VALID_IN & (bad_cmode(CMOD_A_IN) |
                                       (PAIR_IN & bad_cmode(CMOD_B_IN)));           // [RL2]
    end
  end

endmodule : pilc_checker

`default_nettype wire

// file: testbench/pilc_chk.sv
// Concurrent checks on the legality checker ports
`timescale 1ns/1ps
`default_nettype none
module pilc_chk #(
  parameter int unsigned LEN_W = 3
) (
  input wire logic                      CLK_IN, SRST_IN, CE_IN, VALID_IN, PAIR_IN, REPEAT_IN,
  input wire logic                      LEGACY_COMPAT_BIT_IN, PAR_EN_A_IN, PAR_EN_B_IN, SOFT_DUAL_IN,
  input wire logic [LEN_W-1:0]          LEN_A_IN, LEN_B_IN,
  input wire logic [pilc_pkg::CL_W-1:0] CLASS_A_IN,
  input wire logic [pilc_pkg::OP_W-1:0] OPS_A_IN, OPS_B_IN,
  input wire logic                      MMR_TGT_A_IN,
  input wire logic [1:0]                DAGEN_A_IN, DAGEN_B_IN,
  input wire pilc_pkg::pilc_cmod_t      CMOD_A_IN,
  input wire logic                      ISSUE_OUT, ISSUE_PAIR_OUT, ILLEGAL_PAIR_OUT,
  input wire logic                      NOT_REPEATABLE_OUT, BUS_ERROR_IRQ_OUT, COEF_IDX_AUX_OUT
);
  // ----------------------------------------------------------------
  // Request and refusal sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  sequence s_req;
    CE_IN && VALID_IN;
  endsequence
  sequence s_pair;
    CE_IN && VALID_IN && PAIR_IN;
  endsequence
  sequence s_refuse;
    ILLEGAL_PAIR_OUT && !ISSUE_PAIR_OUT;
  endsequence
  property p_size;
    s_pair ##0 (LEN_A_IN + LEN_B_IN > 6) |=> s_refuse;
  endproperty
  property p_enable;
    s_pair ##0 (!PAR_EN_A_IN && !PAR_EN_B_IN && !SOFT_DUAL_IN) |=> s_refuse;
  endproperty
  property p_ops;
    s_pair ##0 ((OPS_A_IN & OPS_B_IN) != '0) |=> s_refuse;
  endproperty
  property p_agen;
    s_pair ##0 (DAGEN_A_IN + DAGEN_B_IN > 2) |=> s_refuse;
  endproperty
  property p_mmr_byte;
    s_req ##0 (CLASS_A_IN[pilc_pkg::CL_BYTE_ACC] && MMR_TGT_A_IN) |=> BUS_ERROR_IRQ_OUT && !ISSUE_OUT;
  endproperty
  property p_repeat;
    s_req ##0 (REPEAT_IN && CLASS_A_IN[pilc_pkg::CL_REPEAT]) |=> NOT_REPEATABLE_OUT;
  endproperty
  property p_index;
    s_req ##0 (CMOD_A_IN == pilc_pkg::CM_IDX) |=> COEF_IDX_AUX_OUT == $past(LEGACY_COMPAT_BIT_IN);
  endproperty
  property p_pulse;
    CE_IN && !VALID_IN |=> !ILLEGAL_PAIR_OUT && !ISSUE_OUT;
  endproperty
  a_size: assert property (p_size) else $error("oversize pair issued");
  a_enable: assert property (p_enable) else $error("pair without enable issued");
  a_ops: assert property (p_ops) else $error("shared operator pair issued");
  a_agen: assert property (p_agen) else $error("data agen overuse issued");
  a_mmr_byte: assert property (p_mmr_byte) else $error("byte access to mapped register");
  a_repeat: assert property (p_repeat) else $error("repeat not flagged");
  a_index: assert property (p_index) else $error("wrong index source");
  a_pulse: assert property (p_pulse) else $error("output without request");
endmodule : pilc_chk
bind pilc_checker pilc_chk #(.LEN_W(LEN_W)) u_chk (
  .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .CE_IN(CE_IN), .VALID_IN(VALID_IN), .PAIR_IN(PAIR_IN),
  .REPEAT_IN(REPEAT_IN), .LEGACY_COMPAT_BIT_IN(LEGACY_COMPAT_BIT_IN), .PAR_EN_A_IN(PAR_EN_A_IN),
  .PAR_EN_B_IN(PAR_EN_B_IN), .SOFT_DUAL_IN(SOFT_DUAL_IN), .LEN_A_IN(LEN_A_IN), .LEN_B_IN(LEN_B_IN),
  .CLASS_A_IN(CLASS_A_IN), .OPS_A_IN(OPS_A_IN), .OPS_B_IN(OPS_B_IN), .MMR_TGT_A_IN(MMR_TGT_A_IN),
  .DAGEN_A_IN(DAGEN_A_IN), .DAGEN_B_IN(DAGEN_B_IN), .CMOD_A_IN(CMOD_A_IN), .ISSUE_OUT(ISSUE_OUT),
  .ISSUE_PAIR_OUT(ISSUE_PAIR_OUT), .ILLEGAL_PAIR_OUT(ILLEGAL_PAIR_OUT),
  .NOT_REPEATABLE_OUT(NOT_REPEATABLE_OUT), .BUS_ERROR_IRQ_OUT(BUS_ERROR_IRQ_OUT),
  .COEF_IDX_AUX_OUT(COEF_IDX_AUX_OUT)
);
`default_nettype wire

// file: testbench/pilc_exec_model.sv
// Execution side model counting issued pairs
`timescale 1ns/1ps
`default_nettype none
module pilc_exec_model (
  input  wire logic  clk_in,
  input  wire logic  srst_in,
  input  wire logic  issue_in,
  input  wire logic  issue_pair_in,
  output logic [15:0] pair_count_out
);
  // Both slots retire in the one cycle of an issued pair
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pair_count_out <= 16'h0000;
    end else if (issue_in && issue_pair_in) begin
      pair_count_out <= pair_count_out + 16'h0001;
    end
  end
endmodule : pilc_exec_model
`default_nettype wire

// file: testbench/parallel_issue_legality_check_tb.sv
// Self-checking bench for the parallel issue legality checker
`timescale 1ns/1ps
`default_nettype none
module parallel_issue_legality_check_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, srst, ce, valid, pair, rpt, compat, pe_a, pe_b, sd, io_a, io_b, mt_a, mt_b, cg_a, cg_b;
  logic sg_a, sg_b, we_a, we_b, pm_a, pm_b, cu_a, cu_b, xy, xu, yu, iss, iss_p, ill, nrp, berr, sbu, cix, cme;
  logic [2:0]                   len_a, len_b, pid_a, pid_b;
  logic [1:0]                   dg_a, dg_b, ps_a, ps_b;
  logic [pilc_pkg::OP_W-1:0]    op_a, op_b;
  logic [5:0]                   wr_a, wr_b;
  logic [pilc_pkg::QF_W-1:0]    q_a, q_b;
  logic [pilc_pkg::CL_W-1:0]    cl_a, cl_b;
  logic [15:0]                  sb_a, sb_b, pair_count;
  logic [63:0]                  sw_a, sw_b;
  pilc_pkg::pilc_amode_t        am_a, am_b;
  pilc_pkg::pilc_cmod_t         cm_a, cm_b;
  int                           bad_count, compares, exp_pairs;
  localparam int SPK [7] = '{pilc_pkg::CL_CALL, pilc_pkg::CL_PUSH, pilc_pkg::CL_POP, pilc_pkg::CL_RET,
                             pilc_pkg::CL_RETI, pilc_pkg::CL_TRAP, pilc_pkg::CL_SWINT};
  localparam int NRP [16] = '{0, 1, 2, 3, 4, 5, 6, 9, 10, 11, 12, 13, 14, 15, 16, 17};
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  pilc_checker dut (
    .CLK_IN(clk), .SRST_IN(srst), .CE_IN(ce), .VALID_IN(valid), .PAIR_IN(pair), .REPEAT_IN(rpt),
    .LEGACY_COMPAT_BIT_IN(compat), .LEN_A_IN(len_a), .LEN_B_IN(len_b), .PAR_EN_A_IN(pe_a),
    .PAR_EN_B_IN(pe_b), .SOFT_DUAL_IN(sd), .CLASS_A_IN(cl_a), .CLASS_B_IN(cl_b), .OPS_A_IN(op_a),
    .OPS_B_IN(op_b), .QUAL_A_IN(q_a), .QUAL_B_IN(q_b), .AMODE_A_IN(am_a), .AMODE_B_IN(am_b),
    .IO_ACC_A_IN(io_a), .IO_ACC_B_IN(io_b), .MMR_TGT_A_IN(mt_a), .MMR_TGT_B_IN(mt_b), .DAGEN_A_IN(dg_a),
    .DAGEN_B_IN(dg_b), .CAGEN_A_IN(cg_a), .CAGEN_B_IN(cg_b), .SAGEN_A_IN(sg_a), .SAGEN_B_IN(sg_b),
    .WR_EN_A_IN(we_a), .WR_EN_B_IN(we_b), .WR_REG_A_IN(wr_a), .WR_REG_B_IN(wr_b), .SWAP_SET_A_IN(sw_a),
    .SWAP_SET_B_IN(sw_b), .PTR_MOD_A_IN(pm_a), .PTR_MOD_B_IN(pm_b), .PTR_ID_A_IN(pid_a),
    .PTR_ID_B_IN(pid_b), .PTR_STEP_A_IN(ps_a), .PTR_STEP_B_IN(ps_b), .CMOD_A_IN(cm_a), .CMOD_B_IN(cm_b),
    .CUNS_A_IN(cu_a), .CUNS_B_IN(cu_b), .XY_DUAL_IN(xy), .XUNS_IN(xu), .YUNS_IN(yu), .STBIT_A_IN(sb_a),
    .STBIT_B_IN(sb_b), .ISSUE_OUT(iss), .ISSUE_PAIR_OUT(iss_p), .ILLEGAL_PAIR_OUT(ill),
    .NOT_REPEATABLE_OUT(nrp), .BUS_ERROR_IRQ_OUT(berr), .STBIT_UNDEF_OUT(sbu), .COEF_IDX_AUX_OUT(cix),
    .COEF_MODE_ERR_OUT(cme)
  );
  pilc_exec_model u_exec (
    .clk_in(clk), .srst_in(srst), .issue_in(iss), .issue_pair_in(iss_p), .pair_count_out(pair_count)
  );
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic base;
    {rpt, compat, pe_b, sd, io_a, io_b, mt_a, mt_b, cg_a, cg_b, sg_a, sg_b, we_a, we_b} = '0;
    {pm_a, pm_b, cu_a, cu_b, xy, xu, yu, cl_a, cl_b, q_a, q_b, sw_a, sw_b, sb_a, sb_b} = '0;
    {pid_a, pid_b, ps_a, ps_b, dg_b} = '0;
    am_a = pilc_pkg::AM_IND;
    am_b = pilc_pkg::AM_NONE;
    cm_a = pilc_pkg::CM_NONE;
    cm_b = pilc_pkg::CM_NONE;
    {pair, pe_a, len_a, len_b, dg_a} = {1'b1, 1'b1, 3'h2, 3'h2, 2'h1};
    {op_a, op_b, wr_a, wr_b} = {6'h01, 6'h10, 6'h01, 6'h02};
  endtask : base
  task automatic send;
    valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
  endtask : send
  task automatic cmp(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t output got %b expected %b", $time, got, exp);
    end
  endtask : cmp
  task automatic try(input logic ill_exp);
    send();
    cmp(ill, ill_exp);
    cmp(iss_p, !ill_exp);
    if (!ill_exp) exp_pairs++;
  endtask : try
  task automatic finish_test;
    $display("Mismatches %0d in %0d comparisons", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_pairing;
    base(); len_a = 3'h3; len_b = 3'h3; try(1'b0);
    len_b = 3'h4; try(1'b1);
    base(); pe_a = 1'b0; try(1'b1);
    pe_b = 1'b1; try(1'b0);
    pe_b = 1'b0; sd = 1'b1; try(1'b0);
    base();
    for (int i = 2; i <= 5; i++) begin
      am_b = pilc_pkg::pilc_amode_t'(i[2:0]); try(1'b1);
    end
    for (int i = pilc_pkg::CL_FAR_BRANCH; i <= pilc_pkg::CL_TRAP; i++) begin
      base(); cl_b[i] = 1'b1; try(1'b1);
    end
    for (int i = pilc_pkg::QF_MMR; i <= pilc_pkg::QF_LIN_SFX; i++) begin
      base(); q_a[i] = 1'b1; try(1'b1);
    end
  endtask : t_pairing
  task automatic t_resources;
    base(); {we_a, we_b} = 2'b11; try(1'b0);
    wr_b = wr_a; try(1'b1);
    base(); {pm_a, pm_b, pid_a, pid_b, ps_a, ps_b} = {2'b11, 3'h2, 3'h2, 2'h1, 2'h1}; try(1'b0);
    ps_b = 2'h2; try(1'b1);
    base(); cl_a[pilc_pkg::CL_SWAP] = 1'b1; sw_a[5] = 1'b1; we_b = 1'b1; wr_b = 6'h05; try(1'b1);
    base(); cl_a[pilc_pkg::CL_SP_MOD] = 1'b1; try(1'b0);
    foreach (SPK[i]) begin
      cl_b = '0; cl_b[SPK[i]] = 1'b1; try(1'b1);
    end
    for (int i = 0; i < 6; i++) begin
      base(); op_a = 6'(1 << i); op_b = op_a; try(1'b1);
    end
    base(); dg_b = 2'h1; try(1'b0);
    dg_b = 2'h2; try(1'b1);
    base(); {cg_a, cg_b} = 2'b11; try(1'b1);
    base(); {sg_a, sg_b} = 2'b11; try(1'b1);
  endtask : t_resources
  task automatic t_coef;
    base(); cm_a = pilc_pkg::CM_INC; cm_b = pilc_pkg::CM_INC; try(1'b0);
    cm_b = pilc_pkg::CM_DEC; try(1'b1);
    cm_b = pilc_pkg::CM_INC; cu_a = 1'b1; try(1'b1);
    cu_b = 1'b1; try(1'b0);
    base(); {xy, xu} = 2'b11; try(1'b1);
    yu = 1'b1; try(1'b0);
    base(); pair = 1'b0;
    for (int m = 1; m <= 4; m++) begin
      for (int c = 0; c < 2; c++) begin
        cm_a = pilc_pkg::pilc_cmod_t'(m[2:0]); compat = c[0]; send();
        cmp(cme, 1'b0);
        cmp(cix, m == 4 && c == 1);
      end
    end
    cm_a = pilc_pkg::pilc_cmod_t'(3'h5); send();
    cmp(cme, 1'b1);
  endtask : t_coef
  task automatic t_status_bus;
    base(); sb_a = 16'h0004; sb_b = 16'h0004; send(); exp_pairs++;
    cmp(sbu, 1'b1);
    cmp(iss_p, 1'b1);
    sb_b = 16'h0008; send(); exp_pairs++;
    cmp(sbu, 1'b0);
    base(); pair = 1'b0; cl_a[pilc_pkg::CL_BYTE_ACC] = 1'b1; mt_a = 1'b1; send();
    cmp(berr, 1'b1);
    cmp(iss, 1'b0);
    mt_a = 1'b0; send();
    cmp(berr, 1'b0);
    base(); pair = 1'b0; io_a = 1'b1; am_a = pilc_pkg::AM_OFS16; send();
    cmp(berr, 1'b1);
    am_a = pilc_pkg::AM_IND; cl_a[pilc_pkg::CL_DELAY] = 1'b1; send();
    cmp(berr, 1'b1);
    cl_a = '0; send();
    cmp(berr, 1'b0);
  endtask : t_status_bus
  task automatic t_repeat_pulse;
    base(); pair = 1'b0; rpt = 1'b1;
    foreach (NRP[i]) begin
      cl_a = '0; cl_a[NRP[i]] = 1'b1; send();
      cmp(nrp, 1'b1);
    end
    cl_a = '0; send();
    cmp(nrp, 1'b0);
    base(); pe_a = 1'b0; try(1'b1);
    valid = 1'b0; @(posedge clk); @(negedge clk);
    cmp(ill, 1'b0);
  endtask : t_repeat_pulse
  initial begin
    {srst, ce, valid} = 3'b110;
    base();
    repeat (8) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    t_pairing();
    t_resources();
    t_coef();
    t_status_bus();
    t_repeat_pulse();
    cmp(pair_count === 16'(exp_pairs), 1'b1);
    finish_test();
  end
endmodule : parallel_issue_legality_check_tb
`default_nettype wire
